/* hw/status_pin_pkg.sv */
// shared types and constants for the status alert pin logic
package status_pin_pkg;
  // ==========================================================
  // function of the shared pin, fixed at the factory
  typedef enum logic [0:0] {
    FUNC_POWER_OK = 1'b0,
    FUNC_ALERT = 1'b1
  } pin_func_type;

  // converter phase as seen by the status logic
  typedef enum logic [1:0] {
    PHASE_SHUTDOWN = 2'h0,
    PHASE_SOFT_START = 2'h1,
    PHASE_RUN = 2'h2
  } conv_phase_type;

  // ==========================================================
  // converter condition inputs travel together
  typedef struct packed {
    logic in_reg;
    logic fault;
    logic soft_start;
    logic shutdown;
  } conv_cond_type;

  // open-drain pin as two signals
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } od_drive_type;

  // ==========================================================
  // reset values
  localparam logic ALERT_PEND_RST = 1'b1;
  localparam logic PULL_LOW_RST = 1'b1;
  // readback starts low because the pin is pulled low in reset
  localparam logic PIN_LVL_RST = 1'b0;
  localparam logic [2:0] SETTLE_RST = 3'h0;

  // ==========================================================
  // pin readback settling, in clock cycles
  localparam logic [2:0] SETTLE_MAX = 3'h7;
  localparam logic [2:0] PIN_SETTLE_CYC = 3'h4;
endpackage

/* hw/alert_latch.sv */
// sticky alert request for the interrupt function of the status pin
`timescale 1ns/10ps
module alert_latch
  import status_pin_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // conditions
  input wire conv_cond_type cond,
  input wire logic fault_read,
  // state
  output logic pending
);
  logic pend_q;
  logic pend_d;
  logic fault_seen;

  // ==========================================================
  // next pending state; a fault wins over a clearing read
  always_comb begin
    pend_d = pend_q;
    fault_seen = cond.fault;
    if (cond.shutdown) begin
      pend_d = 1'b1;
    end else if (fault_seen) begin
      pend_d = 1'b1;
    end else if (fault_read) begin
      pend_d = 1'b0;
    end
  end

  // register only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q <= ALERT_PEND_RST;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

  fault_rearm_a: assert property (@(posedge clk_sys) disable iff (rst)
    (fault_read && cond.fault) |=> pend_q)
    else $error("fault present at read did not keep request");

  clear_holds_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!pend_q && !cond.fault && !cond.shutdown) |=> !pend_q)
    else $error("request set without a fault");
endmodule

/* hw/power_good_interrupt_output.sv */
// status alert pin driver: power-ok indicator or latched alert request
`timescale 1ns/10ps
module power_good_interrupt_output
  import status_pin_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // factory option
  input wire pin_func_type pin_func,
  // converter conditions, same clock domain
  input wire conv_cond_type cond,
  input wire logic fault_read,
  // status alert pin, open drain
  input wire logic status_alert_pin_in,
  output logic status_alert_pin_out,
  output logic status_alert_pin_oe,
  // state view
  output logic power_ok_indicator,
  output conv_phase_type phase
);
  // ==========================================================
  // internal state
  logic pending;
  logic low_q;
  logic low_d;
  conv_phase_type phase_q;
  conv_phase_type phase_d;
  logic func_alert;
  logic pin_s1_q;
  logic pin_s1_d;
  logic pin_s2_q;
  logic pin_s2_d;
  logic pin_s3_q;
  logic pin_s3_d;
  logic pin_lvl_q;
  logic pin_lvl_d;
  logic [2:0] settle_q;
  logic [2:0] settle_d;

  // ==========================================================
  // sticky alert request
  alert_latch u_latch (
    .clk_sys(clk_sys),
    .rst(rst),
    .cond(cond),
    .fault_read(fault_read),
    .pending(pending)
  );

  // ==========================================================
  // phase and pin-low decision
  always_comb begin
    func_alert = (pin_func == FUNC_ALERT);
    if (cond.shutdown) begin
      phase_d = PHASE_SHUTDOWN;
    end else if (cond.soft_start) begin
      phase_d = PHASE_SOFT_START;
    end else begin
      phase_d = PHASE_RUN;
    end
    if (!func_alert) begin
      low_d = !cond.in_reg || cond.soft_start || cond.shutdown;
    end else begin
      // release needs regulation and a read
      low_d = !cond.in_reg || cond.shutdown || pending || cond.fault;
    end
  end

  // levels sampled each edge
  // registered so the pin never glitches; levels seen once per cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_q <= PULL_LOW_RST;
      phase_q <= PHASE_SHUTDOWN;
    end else begin
      low_q <= low_d;
      phase_q <= phase_d;
    end
  end

  // open drain: only ever drives zero, external pull-up gives the high
  assign status_alert_pin_out = 1'b0;
  assign status_alert_pin_oe = low_q;
  assign power_ok_indicator = !low_q;
  assign phase = phase_q;

  // ==========================================================
  // pin readback: the pull-up sits off chip, so the level is asynchronous
  // three stages; a new level counts only once stages two and three agree
  // limitation: another device holding the pin low also reads as low
  always_comb begin
    pin_s1_d = status_alert_pin_in;
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q;
    pin_lvl_d = pin_lvl_q;
    if (pin_s2_q == pin_s3_q) begin
      pin_lvl_d = pin_s3_q;
    end
    // cycles since the drive last changed, saturating
    settle_d = settle_q;
    if (low_d != low_q) begin
      settle_d = SETTLE_RST;
    end else if (settle_q != SETTLE_MAX) begin
      settle_d = settle_q + 3'h1;
    end
  end

  // pin is held low in reset, so the readback chain starts low too
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= PIN_LVL_RST;
      pin_s2_q <= PIN_LVL_RST;
      pin_s3_q <= PIN_LVL_RST;
      pin_lvl_q <= PIN_LVL_RST;
      settle_q <= SETTLE_RST;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
      pin_lvl_q <= pin_lvl_d;
      settle_q <= settle_d;
    end
  end

  startup_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_POWER_OK && (cond.soft_start || cond.shutdown)) |=> low_q)
    else $error("power-ok released during startup or shutdown");

  under_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cond.in_reg) |=> low_q)
    else $error("pin released while under threshold");

  reg_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_POWER_OK && cond.in_reg && !cond.soft_start && !cond.shutdown)
      |=> !low_q)
    else $error("power-ok not released in regulation");

  // alert stays low without a read
  alert_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && pending) |=> low_q)
    else $error("alert released without a read");

  // clean read releases within two cycles
  read_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && fault_read && !cond.fault && !cond.shutdown
      && cond.in_reg) ##1 (!cond.fault && cond.in_reg && !cond.shutdown
      && pin_func == FUNC_ALERT) |=> !low_q)
    else $error("alert not released after clean read");

  fault_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && cond.fault) |=> low_q)
    else $error("alert released with fault present");

  level_track_a: assert property (@(posedge clk_sys) disable iff (rst)
    cond.shutdown |=> (phase_q == PHASE_SHUTDOWN))
    else $error("shutdown level not taken at the next edge");

  drive_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    status_alert_pin_oe |-> !status_alert_pin_out)
    else $error("open-drain pin driven high");

  readback_a: assert property (@(posedge clk_sys) disable iff (rst)
    (settle_q >= PIN_SETTLE_CYC) |-> (pin_lvl_q == !low_q))
    else $error("pin level disagrees with open-drain drive");

  ok_no_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_POWER_OK && cond.in_reg && !cond.soft_start && !cond.shutdown
      && cond.fault) |=> !low_q)
    else $error("power-ok pulled low by a fault");

  alert_under_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && !cond.in_reg) |=> low_q)
    else $error("alert released while under threshold");

  alert_shutdown_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && cond.shutdown) |=> low_q)
    else $error("alert released in shutdown");

  refault_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && fault_read && cond.fault) |=> low_q ##1 low_q)
    else $error("alert not held low after read with fault");

  alert_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_func == FUNC_ALERT && !pending && !cond.fault && cond.in_reg && !cond.shutdown)
      |=> !low_q)
    else $error("alert pulled low without a new fault");

  soft_phase_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cond.shutdown && cond.soft_start) |=> (phase_q == PHASE_SOFT_START))
    else $error("soft-start phase not reported");

  run_phase_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cond.shutdown && !cond.soft_start) |=> (phase_q == PHASE_RUN))
    else $error("run phase not reported");
endmodule

/* bench/status_pin_host.sv */
// host side of the status pin: pull-up and wire level
`timescale 1ns/10ps
module status_pin_host (
  // drive from the device
  input wire logic pin_out,
  input wire logic pin_oe,
  // level the host sees
  output logic pin_level
);
  // ==========
  // external pull-up
  // a released pin goes to the pull-up level, never a stale value
  assign pin_level = pin_oe ? pin_out : 1'h1;
endmodule

/* bench/test_power_good_interrupt_output.sv */
// self-checking bench for the status alert pin driver
`timescale 1ns/10ps
module test_power_good_interrupt_output;
  import status_pin_pkg::*;
  // rd_oe: bit 1 read pulse, bit 0 expected pin pull-low
  typedef struct packed {
    pin_func_type func;
    conv_cond_type cond;
    logic [1:0] rd_oe;
    conv_phase_type ph;
  } row_type;
  localparam pin_func_type P = FUNC_POWER_OK;
  localparam pin_func_type A = FUNC_ALERT;
  localparam conv_phase_type S = PHASE_SHUTDOWN;
  localparam conv_phase_type T = PHASE_SOFT_START;
  localparam conv_phase_type R = PHASE_RUN;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  pin_func_type pin_func = P;
  conv_cond_type cond = 4'h1;
  logic fault_read = 1'h0;
  logic pin_out, pin_oe, pin_level, power_ok_indicator;
  conv_phase_type phase;
  int n_fail = 0;
  int comparisons = 0;
  // cond nibble: in_reg, fault, soft_start, shutdown
  row_type rows [17] = '{'{P,4'h1,2'h1,S}, '{P,4'hA,2'h1,T}, '{P,4'h8,2'h0,R},
    '{P,4'h0,2'h1,R}, '{P,4'hC,2'h0,R}, '{A,4'h1,2'h1,S}, '{A,4'h8,2'h1,R},
    '{A,4'h8,2'h2,R}, '{A,4'h8,2'h0,R}, '{A,4'hC,2'h1,R}, '{A,4'h8,2'h1,R},
    '{A,4'hC,2'h3,R}, '{A,4'h8,2'h1,R}, '{A,4'h8,2'h2,R}, '{A,4'h0,2'h1,R},
    '{A,4'h0,2'h3,R}, '{A,4'h8,2'h0,R}};
  power_good_interrupt_output i_power_good_interrupt_output (.clk_sys(clk_sys),
    .rst(rst), .pin_func(pin_func), .cond(cond), .fault_read(fault_read),
    .status_alert_pin_in(pin_level), .status_alert_pin_out(pin_out),
    .status_alert_pin_oe(pin_oe), .power_ok_indicator(power_ok_indicator), .phase(phase));
  status_pin_host i_status_pin_host (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level));
  // ==========
  // clock, 100 ns period
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(string nm, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_ph(conv_phase_type e, conv_phase_type g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR phase expected %h seen %h", e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset held four cycles; outputs checked while it stands
  task automatic do_reset();
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("oe in reset", 1'h1, pin_oe);
    chk("ok in reset", 1'h0, power_ok_indicator);
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
  endtask
  // ==========
  // watchdog: a hang is a mismatch
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
  initial begin
    do_reset();
    // table rows, two edges from input to checked pin
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_sys);
      if (rows[i].func !== pin_func) begin
        pin_func <= rows[i].func;
        do_reset();
      end
      cond <= rows[i].cond;
      fault_read <= rows[i].rd_oe[1];
      @(posedge clk_sys);
      fault_read <= 1'h0;
      @(posedge clk_sys);
      #1;
      chk("oe", rows[i].rd_oe[0], pin_oe);
      chk("pin", !rows[i].rd_oe[0], pin_level);
      chk("power_ok", !rows[i].rd_oe[0], power_ok_indicator);
      chk_ph(rows[i].ph, phase);
    end
    // one-cycle fault blip latches until a read; release lags the read an edge
    @(posedge clk_sys);
    cond <= 4'hC;
    @(posedge clk_sys);
    cond <= 4'h8;
    @(posedge clk_sys);
    #1;
    chk("oe after blip", 1'h1, pin_oe);
    @(posedge clk_sys);
    fault_read <= 1'h1;
    @(posedge clk_sys);
    fault_read <= 1'h0;
    #1;
    chk("oe at read", 1'h1, pin_oe);
    @(posedge clk_sys);
    #1;
    chk("oe after read", 1'h0, pin_oe);
    // reset raised at an edge must pull the pin in that step, not one edge later
    @(posedge clk_sys);
    rst <= 1'h1;
    #1;
    chk("oe async reset", 1'h1, pin_oe);
    do_reset();
    // reset sets pending: pin stays low after release until a read
    repeat (2) begin
      @(posedge clk_sys);
      #1;
      chk("oe after release", 1'h1, pin_oe);
    end
    summarize();
  end
endmodule
